// ===== core/dual_prescaled_timer_unit.sv
// Dual prescaled timer unit with register file access and timer output line
module dual_prescaled_timer_unit
  import timer_unit_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  input  wire logic       port_three_line_one,
  output logic            timer_output_line,
  output logic            timer_output_enable,
  output logic            counter_a_request,
  output logic            counter_b_request,
  output logic            input_edge_request,
  output logic [1:0]      input_mode
);

  // ****************************************
  // Register decode
  // ****************************************
  wire wr_mode  = reg_wr && (reg_addr == TIMER_MODE_ADDR);
  wire wr_cnt_a = reg_wr && (reg_addr == COUNTER_A_ADDR);
  wire wr_cnt_b = reg_wr && (reg_addr == COUNTER_B_ADDR);
  wire wr_pre_a = reg_wr && (reg_addr == PRESCALER_A_ADDR);
  wire wr_pre_b = reg_wr && (reg_addr == PRESCALER_B_ADDR);
  wire wr_pmode = reg_wr && (reg_addr == PORT_THREE_MODE_ADDR);
  wire wr_pdata = reg_wr && (reg_addr == PORT_THREE_DATA_ADDR);

  logic [7:0] timer_mode_control;
  logic [7:0] port_three_mode_config;
  logic [7:0] prescaler_a;
  logic [7:0] prescaler_b;
  logic [7:0] init_a;
  logic [7:0] init_b;
  logic       port_data_six;
  logic       toggle_ff;
  logic       internal_clock;
  logic       edge_prev;

  // ****************************************
  // Per-timer control strobes
  // ****************************************
  wire [1:0] load_pulse;
  wire [1:0] start_pulse;
  wire [1:0] enable_bits;
  wire [1:0] tick;
  wire [1:0] eoc;
  wire [7:0] count [2];
  wire [5:0] pre_init [2];
  wire [7:0] cnt_init [2];
  wire [1:0] cont_mode;

  assign enable_bits = {timer_mode_control[ENABLE_B_BIT], timer_mode_control[ENABLE_A_BIT]};
  assign load_pulse  = {wr_mode && reg_wdata[LOAD_B_BIT], wr_mode && reg_wdata[LOAD_A_BIT]};
  // Counting starts on the write that turns the enable bit on
  assign start_pulse = {wr_mode && reg_wdata[ENABLE_B_BIT] && !enable_bits[1],
                        wr_mode && reg_wdata[ENABLE_A_BIT] && !enable_bits[0]};
  assign pre_init[0] = prescaler_a[7:MODULO_LSB];
  assign pre_init[1] = prescaler_b[7:MODULO_LSB];
  assign cnt_init[0] = init_a;
  assign cnt_init[1] = init_b;
  assign cont_mode   = {prescaler_b[CONT_MODE_BIT], prescaler_a[CONT_MODE_BIT]};

  // ****************************************
  // Timer channels
  // ****************************************
  // Each timer owns its divider so its first tick is tied to its own enable
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_timer
      rate_divider #(.DIV(CRYSTAL_PER_TIMER)) u_div (
        .sys_clk (sys_clk),
        .srst    (srst),
        .restart (start_pulse[gi]),
        .run     (enable_bits[gi]),
        .tick    (tick[gi])
      );
      timer_channel u_chan (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .tick      (tick[gi]),
        .load      (load_pulse[gi]),
        .run_en    (enable_bits[gi]),
        .cont_mode (cont_mode[gi]),
        .pre_init  (pre_init[gi]),
        .cnt_init  (cnt_init[gi]),
        .count     (count[gi]),
        .eoc       (eoc[gi])
      );
    end
  endgenerate

  // ****************************************
  // Register storage
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      timer_mode_control <= TIMER_MODE_RESET;
    end else if (wr_mode) begin
      timer_mode_control <= reg_wdata;
    end else begin
      // Load bits are strobes; they drop on the next internal clock
      timer_mode_control[LOAD_A_BIT] <= 1'b0;
      timer_mode_control[LOAD_B_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      prescaler_a            <= PRESCALER_RESET;
      prescaler_b            <= PRESCALER_RESET;
      init_a                 <= COUNTER_RESET;
      init_b                 <= COUNTER_RESET;
      port_three_mode_config <= PORT_MODE_RESET;
    end else begin
      if (wr_pre_a) prescaler_a <= reg_wdata;
      if (wr_pre_b) prescaler_b <= reg_wdata;
      if (wr_cnt_a) init_a <= reg_wdata;
      if (wr_cnt_b) init_b <= reg_wdata;
      if (wr_pmode) port_three_mode_config <= reg_wdata;
    end
  end

  // ****************************************
  // Output source selection
  // ****************************************
  output_sel_type out_sel;
  assign out_sel = output_sel_type'(timer_mode_control[OUTPUT_SEL_LSB +: 2]);

  // A load that sets the selection in the same write follows the new choice
  output_sel_type write_sel;
  assign write_sel = output_sel_type'(reg_wdata[OUTPUT_SEL_LSB +: 2]);

  wire timer_out_active = (out_sel != OUT_OFF);
  wire sel_load = (write_sel == OUT_TIMER_A && load_pulse[0]) ||
                  (write_sel == OUT_TIMER_B && load_pulse[1]);
  wire sel_eoc  = (out_sel == OUT_TIMER_A && eoc[0]) ||
                  (out_sel == OUT_TIMER_B && eoc[1]);

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      toggle_ff      <= 1'b1;
      internal_clock <= 1'b0;
      port_data_six  <= 1'b1;
    end else begin
      internal_clock <= !internal_clock;
      if (sel_load) begin
        toggle_ff <= 1'b1;
      end else if (sel_eoc) begin
        toggle_ff <= !toggle_ff;
      end
      // Port data is locked while the line carries a timer function
      if (wr_pdata && !timer_out_active) begin
        port_data_six <= reg_wdata[OUT_LINE_BIT];
      end
    end
  end

  logic line_level;
  always_comb begin
    unique case (out_sel)
      OUT_OFF:      line_level = port_data_six;
      OUT_TIMER_A,
      OUT_TIMER_B:  line_level = toggle_ff;
      OUT_INTERNAL: line_level = internal_clock;
    endcase
  end

  assign timer_output_line   = line_level;
  // Direction is software's job; bit low means output
  assign timer_output_enable = !port_three_mode_config[OUT_DIR_BIT];

  // ****************************************
  // Requests and input edge
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      edge_prev          <= 1'b1;
      input_edge_request <= 1'b0;
    end else begin
      edge_prev          <= port_three_line_one;
      input_edge_request <= edge_prev && !port_three_line_one;
    end
  end

  assign counter_a_request = eoc[0];
  assign counter_b_request = eoc[1];
  // Input functions are decoded elsewhere; only the selection is held here
  assign input_mode = timer_mode_control[INPUT_MODE_LSB +: 2];

  // ****************************************
  // Register read
  // ****************************************
  logic [7:0] next_rdata;
  always_comb begin
    unique case (reg_addr)
      TIMER_MODE_ADDR:      next_rdata = timer_mode_control;
      COUNTER_A_ADDR:       next_rdata = count[0];
      COUNTER_B_ADDR:       next_rdata = count[1];
      PRESCALER_A_ADDR,
      PRESCALER_B_ADDR,
      PORT_THREE_MODE_ADDR: next_rdata = WRITE_ONLY_READ;
      PORT_THREE_DATA_ADDR: next_rdata = {1'b0, line_level, 6'h00};
      default:              next_rdata = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata <= UNMAPPED_READ;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  AST_LOAD_SELF_CLEAR: assert property (@(posedge sys_clk) disable iff (srst)
    wr_mode && reg_wdata[LOAD_A_BIT] ##1 !wr_mode |=> !timer_mode_control[LOAD_A_BIT])
    else $error("Load bit did not clear itself");
  AST_OUT_FORCED_HIGH: assert property (@(posedge sys_clk) disable iff (srst)
    sel_load |=> toggle_ff)
    else $error("Output flip-flop not forced high on load");
  AST_OUT_TOGGLE: assert property (@(posedge sys_clk) disable iff (srst)
    sel_eoc && !sel_load |=> toggle_ff != $past(toggle_ff))
    else $error("Output did not toggle at end-of-count");
  AST_PORT_LOCK: assert property (@(posedge sys_clk) disable iff (srst)
    wr_pdata && timer_out_active |=> $stable(port_data_six))
    else $error("Port write changed line under timer output");
  AST_INTERNAL_CLOCK: assert property (@(posedge sys_clk) disable iff (srst)
    out_sel == OUT_INTERNAL ##1 out_sel == OUT_INTERNAL |->
      timer_output_line != $past(timer_output_line))
    else $error("Internal clock not driven at half crystal rate");
  AST_EDGE_REQUEST: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(port_three_line_one) |=> input_edge_request ##1 !input_edge_request)
    else $error("Falling input edge did not raise one request");

  // ****************************************
  // Load and output checks
  // ****************************************
  AST_LOAD_B_SELF_CLEAR: assert property (@(posedge sys_clk) disable iff (srst)
    wr_mode && reg_wdata[LOAD_B_BIT] ##1 !wr_mode |=> !timer_mode_control[LOAD_B_BIT])
    else $error("Load bit B did not clear itself");
  AST_LOAD_A_SETS_LINE: assert property (@(posedge sys_clk) disable iff (srst)
    wr_mode && write_sel == OUT_TIMER_A && reg_wdata[LOAD_A_BIT] |=> timer_output_line)
    else $error("Line not high after load of timer A");
  AST_LOAD_B_SETS_LINE: assert property (@(posedge sys_clk) disable iff (srst)
    wr_mode && write_sel == OUT_TIMER_B && reg_wdata[LOAD_B_BIT] |=> timer_output_line)
    else $error("Line not high after load of timer B");
  // Judged from the request pins, so a broken select path is caught too
  AST_LINE_TOGGLES_A: assert property (@(posedge sys_clk) disable iff (srst)
    counter_a_request && out_sel == OUT_TIMER_A && !wr_mode |=>
      timer_output_line != $past(timer_output_line))
    else $error("Line did not follow timer A end-of-count");
  AST_LINE_TOGGLES_B: assert property (@(posedge sys_clk) disable iff (srst)
    counter_b_request && out_sel == OUT_TIMER_B && !wr_mode |=>
      timer_output_line != $past(timer_output_line))
    else $error("Line did not follow timer B end-of-count");

  // ****************************************
  // Request checks
  // ****************************************
  AST_REQ_A_PULSE: assert property (@(posedge sys_clk) disable iff (srst)
    counter_a_request |=> !counter_a_request)
    else $error("Timer A request longer than one cycle");
  AST_REQ_B_PULSE: assert property (@(posedge sys_clk) disable iff (srst)
    counter_b_request |=> !counter_b_request)
    else $error("Timer B request longer than one cycle");
  // Requests can only follow a cycle in which counting was enabled
  AST_IDLE_A_QUIET: assert property (@(posedge sys_clk) disable iff (srst)
    !enable_bits[0] |=> !counter_a_request)
    else $error("Timer A requested while idle");
  AST_IDLE_B_QUIET: assert property (@(posedge sys_clk) disable iff (srst)
    !enable_bits[1] |=> !counter_b_request)
    else $error("Timer B requested while idle");

  // ****************************************
  // Read-back checks
  // ****************************************
  AST_READ_COUNT_A: assert property (@(posedge sys_clk) disable iff (srst)
    reg_rd && reg_addr == COUNTER_A_ADDR |=> reg_rdata == $past(count[0]))
    else $error("Counter A read not the live count");
  AST_READ_COUNT_B: assert property (@(posedge sys_clk) disable iff (srst)
    reg_rd && reg_addr == COUNTER_B_ADDR |=> reg_rdata == $past(count[1]))
    else $error("Counter B read not the live count");
  AST_READ_LINE: assert property (@(posedge sys_clk) disable iff (srst)
    reg_rd && reg_addr == PORT_THREE_DATA_ADDR |=> reg_rdata[OUT_LINE_BIT] == $past(timer_output_line))
    else $error("Port read not the line level");

  // ****************************************
  // Port and mode checks
  // ****************************************
  AST_PORT_DRIVES_LINE: assert property (@(posedge sys_clk) disable iff (srst)
    wr_pdata && !timer_out_active ##1 out_sel == OUT_OFF |->
      timer_output_line == $past(reg_wdata[OUT_LINE_BIT]))
    else $error("Port data did not reach the line");
  AST_DIRECTION: assert property (@(posedge sys_clk) disable iff (srst)
    wr_pmode |=> timer_output_enable == !$past(reg_wdata[OUT_DIR_BIT]))
    else $error("Line direction does not follow mode bit");
  AST_INPUT_MODE_HELD: assert property (@(posedge sys_clk) disable iff (srst)
    wr_mode |=> input_mode == $past(reg_wdata[INPUT_MODE_LSB +: 2]))
    else $error("Input function code not held");

endmodule

// ===== core/rate_divider.sv
// Restartable enable divider producing the timer clock
module rate_divider
  import timer_unit_pkg::*;
#(
  parameter int DIV = CRYSTAL_PER_TIMER
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic restart,
  input  wire logic run,
  output logic      tick
);

  localparam int W = $clog2(DIV);

  if (DIV < 2) begin : g_bad_div
    $error("rate_divider: DIV below 2");
  end

  logic [W-1:0] phase;

  // Restart aligns phase so the first tick lands a fixed time after enable
  always_ff @(posedge sys_clk) begin
    if (srst || restart) begin
      phase <= '0;
    end else if (run) begin
      phase <= (phase == W'(DIV - 1)) ? '0 : phase + 1'b1;
    end
  end

  assign tick = run && (phase == W'(DIV - 1));

  AST_FIRST_TICK: assert property (@(posedge sys_clk) disable iff (srst)
    restart ##1 (run && !restart) [*8] |-> tick)
    else $error("First timer tick not eight cycles after enable");

endmodule

// ===== core/timer_channel.sv
// One timer: 6-bit prescaler feeding an 8-bit down-counter
module timer_channel
  import timer_unit_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       tick,
  input  wire logic       load,
  input  wire logic       run_en,
  input  wire logic       cont_mode,
  input  wire logic [5:0] pre_init,
  input  wire logic [7:0] cnt_init,
  output logic [7:0]      count,
  output logic            eoc
);

  logic [5:0] pre;
  logic       running;
  wire        step      = tick && run_en && running && !load;
  wire        pre_end   = (pre == 6'h01);
  wire        cnt_end   = (count == 8'h01);
  wire        final_eoc = step && pre_end && cnt_end;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pre     <= 6'h00;
      count   <= COUNTER_RESET;
      running <= 1'b0;
      eoc     <= 1'b0;
    end else begin
      eoc <= final_eoc;
      if (load) begin
        pre     <= pre_init;
        count   <= cnt_init;
        running <= 1'b1;
      end else if (step) begin
        // Zero modulo wraps through 63 so it divides by 64
        pre <= pre_end ? pre_init : pre - 1'b1;
        if (pre_end) begin
          if (cnt_end) begin
            count   <= cont_mode ? cnt_init : 8'h00;
            running <= cont_mode;
          end else begin
            count <= count - 1'b1;
          end
        end
      end
    end
  end

  AST_LOAD_COPIES: assert property (@(posedge sys_clk) disable iff (srst)
    load |=> count == $past(cnt_init) && pre == $past(pre_init))
    else $error("Load did not copy initial values");
  AST_FREEZE: assert property (@(posedge sys_clk) disable iff (srst)
    !run_en && !load |=> $stable(count) && $stable(pre))
    else $error("Counter moved while disabled");
  AST_SINGLE_STOP: assert property (@(posedge sys_clk) disable iff (srst)
    final_eoc && !cont_mode |=> count == 8'h00 ##1 ($past(load) || $stable(count)))
    else $error("Single-pass end-of-count did not rest at zero");
  AST_PRE_NEVER_ZERO: assert property (@(posedge sys_clk) disable iff (srst)
    step && pre_end |=> pre == $past(pre_init))
    else $error("Prescaler did not reload its modulo");

endmodule

// ===== core/timer_unit_pkg.sv
// Constants shared by the dual prescaled timer unit
// Notes on behaviour
// - Load bit copies initial values into down-counters
// - Load bit self-clears on next internal clock
// - Load while running restarts from initial value
// - Timer counts only while its enable bit set
// - First decrement four internal clocks after enable
// - Load and enable together load then count
// - Prescaler reloads modulo after one, never zero
// - Prescaler carry decrements the counter by one
// - Both at end-of-count raise timer request
// - Single-pass stops at zero; continuous reloads
// - Prescaler bit 0 selects single or continuous
// - Clearing enable freezes; setting resumes count
// - Counter read returns live count, no disturbance
// - New initial values apply at next load
// - Counter write sets initial; 00h means 256
// - Interval: eight crystal periods times p times v
// - Mode bits 7:6 select output source
// - Output flip-flop forced high on driving load
// - Each selected end-of-count toggles output
// - Clock selection drives line with crystal over two
// - Port writes ignored under timer output; reads level
// - Timer clock is internal clock divided by four
// - Mode bits 5:4 select timer-input function
// - Input falling edge raises input edge request
package timer_unit_pkg;

  // ****************************************
  // Register file offsets
  // ****************************************
  localparam logic [7:0] PORT_THREE_DATA_ADDR = 8'h03;
  localparam logic [7:0] TIMER_MODE_ADDR      = 8'hf1;
  localparam logic [7:0] COUNTER_B_ADDR       = 8'hf2;
  localparam logic [7:0] PRESCALER_B_ADDR     = 8'hf3;
  localparam logic [7:0] COUNTER_A_ADDR       = 8'hf4;
  localparam logic [7:0] PRESCALER_A_ADDR     = 8'hf5;
  localparam logic [7:0] PORT_THREE_MODE_ADDR = 8'hf7;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int LOAD_A_BIT      = 0;
  localparam int ENABLE_A_BIT    = 1;
  localparam int LOAD_B_BIT      = 2;
  localparam int ENABLE_B_BIT    = 3;
  localparam int INPUT_MODE_LSB  = 4;
  localparam int OUTPUT_SEL_LSB  = 6;
  localparam int CONT_MODE_BIT   = 0;
  localparam int MODULO_LSB      = 2;
  localparam int OUT_DIR_BIT     = 5;
  localparam int OUT_LINE_BIT    = 6;

  // ****************************************
  // Reset and read values
  // ****************************************
  localparam logic [7:0] TIMER_MODE_RESET = 8'h00;
  localparam logic [7:0] PRESCALER_RESET  = 8'h00;
  localparam logic [7:0] COUNTER_RESET    = 8'h00;
  localparam logic [7:0] PORT_MODE_RESET  = 8'hff;
  localparam logic [7:0] WRITE_ONLY_READ  = 8'hff;
  localparam logic [7:0] UNMAPPED_READ    = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CRYSTAL_PER_INTERNAL = 2;
  localparam int INTERNAL_PER_TIMER   = 4;
  localparam int CRYSTAL_PER_TIMER    = CRYSTAL_PER_INTERNAL * INTERNAL_PER_TIMER;

  typedef enum logic [1:0] {
    OUT_OFF, OUT_TIMER_A, OUT_TIMER_B, OUT_INTERNAL
  } output_sel_type;

endpackage

// ===== sim/dual_prescaled_timer_unit_test.sv
// Self-checking bench for the dual prescaled timer unit
module dual_prescaled_timer_unit_test
  import timer_unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk;
  logic       srst;
  logic [7:0] reg_addr;
  logic       reg_wr;
  logic [7:0] reg_wdata;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       port_three_line_one;
  logic       timer_output_line;
  logic       timer_output_enable;
  logic       counter_a_request;
  logic       counter_b_request;
  logic       input_edge_request;
  logic [1:0] input_mode;
  logic       pin_level;
  logic       lvl;
  logic [7:0] rd_val;
  int         failures;
  int         check_count;
  int         n;
  int         p;
  int         v;
  int         q[$];

  dual_prescaled_timer_unit dual_prescaled_timer_unit_i (
    .sys_clk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .port_three_line_one, .timer_output_line, .timer_output_enable,
    .counter_a_request, .counter_b_request, .input_edge_request, .input_mode
  );
  output_pin_model output_pin_model_i (
    .drive_level(timer_output_line), .drive_enable(timer_output_enable), .pin_level(pin_level)
  );

  // ****************************************
  // Reference model and bus tasks
  // ****************************************
  // Zero in either field stands for the largest divisor
  function automatic int interval(input int pp, input int vv);
    return 8 * (pp == 0 ? 64 : pp) * (vv == 0 ? 256 : vv);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // An idle cycle first keeps back-to-back strobes from colliding in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge sys_clk);
    #1 reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    #1 reg_addr = a;
    reg_rd = 1'b1;
    @(posedge sys_clk);
    #1 reg_rd = 1'b0;
    @(posedge sys_clk);
    #1 rd_val = reg_rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    check(rd_val, e);
  endtask

  // Edges from now until the chosen request is seen, capped at lim
  task automatic count_to(input int which, input int lim);
    n = 0;
    do begin
      @(posedge sys_clk);
      #1 n++;
    end while ((which ? counter_b_request : counter_a_request) !== 1'b1 && n < lim);
  endtask

  task automatic give_verdict();
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and scenarios
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // The scenarios need under ten thousand cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    failures++;
    give_verdict();
  end

  initial begin
    srst = 1'b1;
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    port_three_line_one = 1'b1;
    failures = 0;
    check_count = 0;
    void'($urandom(32'hbee0_871f));
    repeat (10) @(posedge sys_clk);
    #1 srst = 1'b0;
    rdc(TIMER_MODE_ADDR, 8'h00);
    rdc(PRESCALER_A_ADDR, WRITE_ONLY_READ);
    rdc(PORT_THREE_MODE_ADDR, WRITE_ONLY_READ);
    rdc(8'h80, UNMAPPED_READ);
    check(timer_output_enable, 1'b0);
    // Single pass on timer A, loaded and started by one write
    wr(PRESCALER_A_ADDR, 8'h04);
    wr(COUNTER_A_ADDR, 8'h02);
    wr(TIMER_MODE_ADDR, 8'h03);
    count_to(0, 100);
    check(n, interval(1, 2));
    count_to(0, 40);
    check(n, 40);
    rdc(COUNTER_A_ADDR, 8'h00);
    rdc(TIMER_MODE_ADDR, 8'h02);
    // Continuous on timer B with random divisors and a new value mid-period
    p = $urandom_range(1, 3);
    v = $urandom_range(1, 3);
    wr(PRESCALER_B_ADDR, {p[5:0], 2'b01});
    wr(COUNTER_B_ADDR, v[7:0]);
    wr(TIMER_MODE_ADDR, 8'h0c);
    count_to(1, 300);
    check(n, interval(p, v));
    wr(COUNTER_B_ADDR, 8'(v + 1));
    q = {interval(p, v) - 2, interval(p, v + 1), interval(p, v + 1)};
    foreach (q[i]) begin
      count_to(1, 300);
      check(n, q[i]);
    end
    // Modulo field of zero divides by sixty-four
    wr(PRESCALER_A_ADDR, 8'h00);
    wr(COUNTER_A_ADDR, 8'h01);
    wr(TIMER_MODE_ADDR, 8'h03);
    count_to(0, 600);
    check(n, 512);
    // Live reads, freeze and resume from the held count
    wr(PRESCALER_A_ADDR, 8'h05);
    wr(COUNTER_A_ADDR, 8'h00);
    wr(TIMER_MODE_ADDR, 8'h03);
    repeat (40) @(posedge sys_clk);
    rd(COUNTER_A_ADDR);
    v = rd_val;
    repeat (20) @(posedge sys_clk);
    rd(COUNTER_A_ADDR);
    check(rd_val < v[7:0], 1'b1);
    wr(TIMER_MODE_ADDR, 8'h00);
    rd(COUNTER_A_ADDR);
    v = rd_val;
    repeat (40) @(posedge sys_clk);
    rdc(COUNTER_A_ADDR, v[7:0]);
    wr(TIMER_MODE_ADDR, 8'h02);
    repeat (40) @(posedge sys_clk);
    rd(COUNTER_A_ADDR);
    check(rd_val < v[7:0] && v[7:0] - rd_val <= 8'd7, 1'b1);
    // Reload in mid-run restarts the full count
    wr(COUNTER_A_ADDR, 8'h04);
    wr(TIMER_MODE_ADDR, 8'h03);
    repeat (18) @(posedge sys_clk);
    wr(TIMER_MODE_ADDR, 8'h03);
    count_to(0, 60);
    check(n >= 24 && n <= 33, 1'b1);
    // Output line: port data, timer A and B toggles, internal clock
    wr(PORT_THREE_MODE_ADDR, 8'hdf);
    check(timer_output_enable, 1'b1);
    wr(PORT_THREE_DATA_ADDR, 8'h00);
    check(pin_level, 1'b0);
    rdc(PORT_THREE_DATA_ADDR, 8'h00);
    wr(PRESCALER_A_ADDR, 8'h05);
    wr(COUNTER_A_ADDR, 8'h02);
    wr(TIMER_MODE_ADDR, 8'h43);
    @(posedge sys_clk);
    #1 check(pin_level, 1'b1);
    wr(PORT_THREE_DATA_ADDR, 8'h00);
    lvl = 1'b1;
    repeat (3) begin
      count_to(0, 40);
      repeat (2) @(posedge sys_clk);
      #1 lvl = !lvl;
      check(pin_level, lvl);
      rdc(PORT_THREE_DATA_ADDR, {1'b0, lvl, 6'h00});
    end
    wr(PRESCALER_B_ADDR, 8'h05);
    wr(COUNTER_B_ADDR, 8'h01);
    wr(TIMER_MODE_ADDR, 8'h8c);
    @(posedge sys_clk);
    #1 check(pin_level, 1'b1);
    count_to(1, 40);
    repeat (2) @(posedge sys_clk);
    #1 check(pin_level, 1'b0);
    wr(TIMER_MODE_ADDR, 8'hc0);
    lvl = pin_level;
    repeat (4) begin
      @(posedge sys_clk);
      #1 check(pin_level, !lvl);
      lvl = pin_level;
    end
    wr(TIMER_MODE_ADDR, 8'h00);
    wr(PORT_THREE_DATA_ADDR, 8'h40);
    check(pin_level, 1'b1);
    wr(PORT_THREE_MODE_ADDR, 8'hff);
    check(timer_output_enable, 1'b0);
    // Input function codes and the falling-edge request
    for (int m = 0; m < 4; m++) begin
      wr(TIMER_MODE_ADDR, {2'b00, m[1:0], 4'h0});
      check(input_mode, m[1:0]);
    end
    port_three_line_one = 1'b0;
    for (n = 0; n < 4 && input_edge_request !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    check(input_edge_request, 1'b1);
    @(posedge sys_clk);
    #1 check(input_edge_request, 1'b0);
    give_verdict();
  end
endmodule

// ===== sim/output_pin_model.sv
// Pad model for the timer output line with an external pull-up
module output_pin_model (
  input  wire logic drive_level,
  input  wire logic drive_enable,
  output logic      pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released pad floats high, so a stale low never passes for a driven one
  assign pin_level = drive_enable ? drive_level : 1'b1;
endmodule
